// ==== hdl/pct_pkg.sv ====
// package for the pulse period capture timer: register map, fields, encodings, state record
package pct_pkg;

	// bus widths
	localparam int ADDR_W = 18;
	typedef logic [ADDR_W-1:0] pct_addr_t;
	typedef logic [31:0] pct_data_t;
	typedef logic [3:0] pct_strb_t;
	typedef logic [1:0] pct_resp_t;

	// register indices as printed; the byte address is four times the index
	localparam logic [15:0] IDX_MODE = 16'hff80;
	localparam logic [15:0] IDX_CTRL = 16'hff81;
	localparam logic [15:0] IDX_IEN = 16'hff82;
	localparam logic [15:0] IDX_STATUS = 16'hff83;
	localparam logic [15:0] IDX_IOC = 16'hff84;
	localparam logic [15:0] IDX_COUNT = 16'hff86;
	localparam logic [15:0] IDX_GRA = 16'hff88;
	localparam pct_addr_t ADDR_MODE = {IDX_MODE, 2'b00};
	localparam pct_addr_t ADDR_CTRL = {IDX_CTRL, 2'b00};
	localparam pct_addr_t ADDR_IEN = {IDX_IEN, 2'b00};
	localparam pct_addr_t ADDR_STATUS = {IDX_STATUS, 2'b00};
	localparam pct_addr_t ADDR_IOC = {IDX_IOC, 2'b00};
	localparam pct_addr_t ADDR_COUNT = {IDX_COUNT, 2'b00};
	localparam pct_addr_t ADDR_GRA = {IDX_GRA, 2'b00};

	// field positions
	localparam int MODE_RUN_BIT = 7;
	localparam int CTRL_CKS_HI = 6;
	localparam int CTRL_CKS_LO = 4;
	localparam int IEN_OVF_BIT = 7;
	localparam int IEN_CAP_BIT = 0;
	localparam int ST_OVF_BIT = 7;
	localparam int ST_CAP_BIT = 0;
	localparam int IOC_FUNC_BIT = 2;
	localparam int IOC_EDGE_HI = 1;
	localparam int IOC_EDGE_LO = 0;

	// clock select codes; any code with the top bit set picks the external clock pin
	localparam logic [2:0] CKS_DIV1 = 3'h0;
	localparam logic [2:0] CKS_DIV2 = 3'h1;
	localparam logic [2:0] CKS_DIV4 = 3'h2;
	localparam logic [2:0] CKS_DIV8 = 3'h3;
	localparam logic [2:0] PRESC_ALL = 3'h7;
	localparam logic [2:0] PRESC_ONE = 3'h1;
	localparam logic [2:0] PRESC_THREE = 3'h3;

	// capture edge codes
	localparam logic [1:0] EDGE_RISE = 2'h0;
	localparam logic [1:0] EDGE_FALL = 2'h1;

	// counter limits and reset values
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	localparam logic [15:0] COUNT_ONE = 16'h0001;
	localparam logic [7:0] RST_REG8 = 8'h00;
	localparam logic [15:0] RST_REG16 = 16'h0000;

	// bus responses
	localparam pct_resp_t RESP_OKAY = 2'h0;
	localparam pct_resp_t RESP_SLVERR = 2'h2;

	// the whole software-visible state travels together
	typedef struct packed {
		logic [7:0] mode;
		logic [7:0] ctrl;
		logic [7:0] ien;
		logic [7:0] status;
		logic [7:0] ioc;
		logic [15:0] count;
		logic [15:0] capture_compare_a;
	} pct_regs_t;

	localparam pct_regs_t REGS_RST = '{RST_REG8, RST_REG8, RST_REG8, RST_REG8, RST_REG8,
		RST_REG16, RST_REG16};

endpackage

// ==== hdl/pct_timer.sv ====
// pulse period capture timer with an axi4-lite register slave
//
// Contract
// - 16-bit up-counter steps by one per tick of the selected count clock.
// - count clock comes from the internal clock or the external clock pin.
// - run bit 7 of timer_mode halts counting at 0, counts at 1.
// - clock select bits 6..4 of timer_control; code 011 is internal clock over eight.
// - wrap from ffff to 0000 sets overflow flag, status bit 7.
// - channel function bit 2 picks compare at 0, capture at 1.
// - edge field 00 rising, 01 falling, 1x either edge of the capture pin.
// - capture copies the counter into capture_compare_a and sets status bit 0.
// - overflow enable bit 7 passes the overflow flag to the interrupt.
// - capture enable bit 0 passes the capture flag to the interrupt.
// - counter and capture register are 16 bits, readable and writable.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
module pct_timer (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address and data
	input wire pct_pkg::pct_addr_t awaddr,
	input wire logic [2:0] awprot,
	input wire logic awvalid,
	output logic awready,
	input wire pct_pkg::pct_data_t wdata,
	input wire pct_pkg::pct_strb_t wstrb,
	input wire logic wvalid,
	output logic wready,
	// axi4-lite write response
	output pct_pkg::pct_resp_t bresp,
	output logic bvalid,
	input wire logic bready,
	// axi4-lite read
	input wire pct_pkg::pct_addr_t araddr,
	input wire logic [2:0] arprot,
	input wire logic arvalid,
	output logic arready,
	output pct_pkg::pct_data_t rdata,
	output pct_pkg::pct_resp_t rresp,
	output logic rvalid,
	input wire logic rready,
	// pins
	input wire logic capture_input_pin,
	input wire logic count_clock_pin,
	// interrupt
	output logic irq
);
	import pct_pkg::*;

	// register state
	pct_regs_t regs_r, regs_nxt;
	logic irq_r, irq_nxt;
	logic [2:0] presc_r, presc_nxt;
	logic [2:0] cap_sync_r, cap_sync_nxt;
	logic [2:0] ext_sync_r, ext_sync_nxt;

	// bus state
	logic aw_held_r, aw_held_nxt;
	pct_addr_t aw_addr_r, aw_addr_nxt;
	logic w_held_r, w_held_nxt;
	pct_data_t w_data_r, w_data_nxt;
	pct_strb_t w_strb_r, w_strb_nxt;
	logic bvalid_r, bvalid_nxt;
	pct_resp_t bresp_r, bresp_nxt;
	logic arready_r, arready_nxt;
	logic awready_r, awready_nxt;
	logic wready_r, wready_nxt;
	logic rvalid_r, rvalid_nxt;
	pct_data_t rdata_r, rdata_nxt;
	pct_resp_t rresp_r, rresp_nxt;

	// decoded helpers
	logic [2:0] cks;
	logic [2:0] presc_mask;
	logic tick, run;
	logic pin_rise, pin_fall;
	logic cap_evt, cmp_evt, ovf_evt;
	logic do_write, do_read, wr_hit, rd_hit;
	logic [31:0] rd_value;
	logic wr_count, wr_gra;

	// byte-lane merge for the low two lanes
	function automatic logic [15:0] merge16(input logic [15:0] old, input pct_data_t d,
		input pct_strb_t s);
		logic [15:0] v;
		v = old;
		if (s[0]) begin
			v[7:0] = d[7:0];
		end
		if (s[1]) begin
			v[15:8] = d[15:8];
		end
		return v;
	endfunction

	// count clock selection: prescaler mask per code, or external pin edge
	always_comb begin
		cks = regs_r.ctrl[CTRL_CKS_HI:CTRL_CKS_LO];
		unique case (cks)
			CKS_DIV1: presc_mask = 3'h0;
			CKS_DIV2: presc_mask = PRESC_ONE;
			CKS_DIV4: presc_mask = PRESC_THREE;
			default: presc_mask = PRESC_ALL;
		endcase
		if (cks[2]) begin
			tick = ext_sync_r[1] & ~ext_sync_r[2];
		end else begin
			tick = (presc_r & presc_mask) == presc_mask;
		end
		run = regs_r.mode[MODE_RUN_BIT];
	end

	// capture pin edges, looked at only after the second sync stage
	always_comb begin
		pin_rise = cap_sync_r[1] & ~cap_sync_r[2];
		pin_fall = ~cap_sync_r[1] & cap_sync_r[2];
		cap_evt = 1'b0;
		if (regs_r.ioc[IOC_FUNC_BIT]) begin
			if (regs_r.ioc[IOC_EDGE_HI]) begin
				cap_evt = pin_rise | pin_fall;
			end else if (regs_r.ioc[IOC_EDGE_HI:IOC_EDGE_LO] == EDGE_FALL) begin
				cap_evt = pin_fall;
			end else begin
				cap_evt = pin_rise;
			end
		end
		cmp_evt = ~regs_r.ioc[IOC_FUNC_BIT] & run & tick & (regs_r.count == regs_r.capture_compare_a);
		ovf_evt = run & tick & (regs_r.count == COUNT_MAX);
	end

	// bus decode
	always_comb begin
		do_write = aw_held_r & w_held_r & ~bvalid_r;
		do_read = arvalid & arready_r;
		wr_hit = 1'b1;
		unique case (aw_addr_r)
			ADDR_MODE, ADDR_CTRL, ADDR_IEN, ADDR_STATUS, ADDR_IOC, ADDR_COUNT, ADDR_GRA: begin
				wr_hit = 1'b1;
			end
			default: wr_hit = 1'b0;
		endcase
		rd_hit = 1'b1;
		rd_value = 32'h0000_0000;
		unique case (araddr)
			ADDR_MODE: rd_value = {24'h00_0000, regs_r.mode};
			ADDR_CTRL: rd_value = {24'h00_0000, regs_r.ctrl};
			ADDR_IEN: rd_value = {24'h00_0000, regs_r.ien};
			ADDR_STATUS: rd_value = {24'h00_0000, regs_r.status};
			ADDR_IOC: rd_value = {24'h00_0000, regs_r.ioc};
			ADDR_COUNT: rd_value = {16'h0000, regs_r.count};
			ADDR_GRA: rd_value = {16'h0000, regs_r.capture_compare_a};
			default: rd_hit = 1'b0;
		endcase
		wr_count = do_write & (aw_addr_r == ADDR_COUNT);
		wr_gra = do_write & (aw_addr_r == ADDR_GRA);
	end

	// next state of the timer registers
	always_comb begin
		logic [7:0] st_set;
		logic [7:0] st_clr;
		st_set = 8'h00;
		st_clr = 8'h00;
		regs_nxt = regs_r;
		presc_nxt = presc_r + PRESC_ONE;
		cap_sync_nxt = {cap_sync_r[1:0], capture_input_pin};
		ext_sync_nxt = {ext_sync_r[1:0], count_clock_pin};
		// counter advance, a software write takes precedence
		if (run & tick) begin
			regs_nxt.count = regs_r.count + COUNT_ONE;
		end
		if (wr_count) begin
			regs_nxt.count = merge16(regs_r.count, w_data_r, w_strb_r);
		end
		// capture copies the live count; a write in the same cycle loses
		if (wr_gra) begin
			regs_nxt.capture_compare_a = merge16(regs_r.capture_compare_a, w_data_r, w_strb_r);
		end
		if (cap_evt) begin
			regs_nxt.capture_compare_a = regs_r.count;
		end
		// plain control registers
		if (do_write & w_strb_r[0]) begin
			if (aw_addr_r == ADDR_MODE) begin
				regs_nxt.mode = w_data_r[7:0];
			end
			if (aw_addr_r == ADDR_CTRL) begin
				regs_nxt.ctrl = w_data_r[7:0];
			end
			if (aw_addr_r == ADDR_IEN) begin
				regs_nxt.ien = w_data_r[7:0];
			end
			if (aw_addr_r == ADDR_IOC) begin
				regs_nxt.ioc = w_data_r[7:0];
			end
		end
		// sticky flags: read of status clears, a new event in that cycle wins
		st_set[ST_OVF_BIT] = ovf_evt;
		st_set[ST_CAP_BIT] = cap_evt | cmp_evt;
		if (do_read & (araddr == ADDR_STATUS)) begin
			st_clr = regs_r.status;
		end
		regs_nxt.status = (regs_r.status & ~st_clr) | st_set;
		// interrupt level from flags gated by enables
		irq_nxt = (regs_nxt.status[ST_OVF_BIT] & regs_nxt.ien[IEN_OVF_BIT])
			| (regs_nxt.status[ST_CAP_BIT] & regs_nxt.ien[IEN_CAP_BIT]);
	end

	// timer registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			regs_r <= REGS_RST;
			irq_r <= 1'b0;
			presc_r <= 3'h0;
			cap_sync_r <= 3'h0;
			ext_sync_r <= 3'h0;
		end else begin
			regs_r <= regs_nxt;
			irq_r <= irq_nxt;
			presc_r <= presc_nxt;
			cap_sync_r <= cap_sync_nxt;
			ext_sync_r <= ext_sync_nxt;
		end
	end

	// next state of the bus slave
	always_comb begin
		aw_held_nxt = aw_held_r;
		aw_addr_nxt = aw_addr_r;
		w_held_nxt = w_held_r;
		w_data_nxt = w_data_r;
		w_strb_nxt = w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		// address and data are taken independently, in either order
		if (awvalid & awready_r) begin
			aw_held_nxt = 1'b1;
			aw_addr_nxt = awaddr;
		end
		if (wvalid & wready_r) begin
			w_held_nxt = 1'b1;
			w_data_nxt = wdata;
			w_strb_nxt = wstrb;
		end
		if (bvalid_r & bready) begin
			bvalid_nxt = 1'b0;
		end
		if (do_write) begin
			aw_held_nxt = 1'b0;
			w_held_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_hit ? RESP_OKAY : RESP_SLVERR;
		end
		if (rvalid_r & rready) begin
			rvalid_nxt = 1'b0;
		end
		if (do_read) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = rd_value;
			rresp_nxt = rd_hit ? RESP_OKAY : RESP_SLVERR;
		end
		awready_nxt = ~aw_held_nxt;
		wready_nxt = ~w_held_nxt;
		arready_nxt = ~rvalid_nxt;
	end

	// bus registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= '0;
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			arready_r <= 1'b0;
		end else begin
			aw_held_r <= aw_held_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_held_r <= w_held_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			arready_r <= arready_nxt;
		end
	end

	// outputs straight from flip-flops
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign irq = irq_r;

	// checks on the timer behaviour and the write response
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	chk_count_step: assert property (
		run && tick && !wr_count |=> regs_r.count == $past(regs_r.count) + COUNT_ONE)
		else $error("counter did not step on a tick");
	chk_count_halt: assert property (
		!run && !wr_count |=> regs_r.count == $past(regs_r.count))
		else $error("counter moved while halted");
	chk_div8_spacing: assert property (
		tick && cks == CKS_DIV8 && $past(cks) == CKS_DIV8 |-> !$past(tick))
		else $error("divide by eight ticked on adjacent cycles");
	chk_ovf_flag: assert property (
		ovf_evt |=> regs_r.status[ST_OVF_BIT]
			&& (regs_r.count == $past(regs_r.count) + COUNT_ONE || $past(wr_count)))
		else $error("overflow did not set its flag");
	chk_cmp_no_copy: assert property (
		!regs_r.ioc[IOC_FUNC_BIT] && !wr_gra |=> regs_r.capture_compare_a == $past(regs_r.capture_compare_a))
		else $error("compare mode register changed without a write");
	chk_cap_copy: assert property (
		cap_evt |=> regs_r.capture_compare_a == $past(regs_r.count) && regs_r.status[ST_CAP_BIT])
		else $error("capture did not copy the count and set the flag");
	chk_irq_ovf: assert property (
		regs_r.status[ST_OVF_BIT] && regs_r.ien[IEN_OVF_BIT] |-> irq)
		else $error("enabled overflow flag did not raise the interrupt");
	chk_irq_gate: assert property (
		irq |-> $past(regs_nxt.status[ST_CAP_BIT] && regs_nxt.ien[IEN_CAP_BIT]
			|| regs_nxt.status[ST_OVF_BIT] && regs_nxt.ien[IEN_OVF_BIT]))
		else $error("interrupt high without an enabled flag");
	chk_flag_sticky: assert property (
		regs_r.status[ST_CAP_BIT] && !(do_read && araddr == ADDR_STATUS)
			|=> regs_r.status[ST_CAP_BIT])
		else $error("capture flag dropped without a status read");
	chk_single_capture: assert property (
		cap_evt && !regs_r.ioc[IOC_EDGE_HI] |=> !cap_evt || regs_r.ioc[IOC_EDGE_HI])
		else $error("one pin transition gave two captures");
	chk_bresp_hold: assert property (
		bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped before it was taken");

	// main scenarios
	cov_capture: cover property (cap_evt && regs_r.ien[IEN_CAP_BIT] ##1 irq);
	cov_overflow: cover property (ovf_evt ##1 regs_r.status[ST_OVF_BIT]);
	cov_read_clear: cover property (do_read && araddr == ADDR_STATUS && regs_r.status != 8'h00);
	cov_two_captures: cover property (cap_evt ##[1:1000] cap_evt);

endmodule

// ==== dv/pct_pulse_src.sv ====
// pulse source model that drives the capture pin of the timer
`timescale 1ns/10ps
module pct_pulse_src (
	// clock
	input wire logic aclk,
	// pulse output
	output logic pulse_pin
);
	initial begin
		pulse_pin = 1'b0;
	end

	// move the pin after a chosen number of edges, so edges come promptly or late
	task automatic drive(input logic v, input int dly);
		repeat (dly) @(posedge aclk);
		pulse_pin <= v;
	endtask
endmodule

// ==== dv/test_pulse_period_capture_timer.sv ====
// self-checking bench for the pulse period capture timer
`timescale 1ns/10ps
module test_pulse_period_capture_timer;
	import pct_pkg::*;
	typedef struct {logic [31:0] lo; logic [31:0] hi; pct_resp_t resp;} pct_exp_t;
	logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_clk, pin;
	logic awready, wready, bvalid, arready, rvalid, irq;
	pct_addr_t awaddr, araddr;
	pct_data_t wdata, rdata;
	pct_resp_t bresp, rresp;
	pct_exp_t rq[$];
	pct_resp_t bq[$];
	pct_exp_t e;
	int miscompares = 0;
	int n_checks = 0;
	logic [15:0] v1, v2, ex, g1, g2;
	logic [31:0] last_rd;
	int n, p;
	pct_strb_t wstrb;
	pct_addr_t regs[7] = '{ADDR_MODE, ADDR_CTRL, ADDR_IEN, ADDR_STATUS, ADDR_IOC, ADDR_COUNT,
		ADDR_GRA};

	pct_timer i_pct_timer (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
		.awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
		.arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
		.rvalid(rvalid), .rready(rready), .capture_input_pin(pin), .count_clock_pin(ext_clk),
		.irq(irq));
	pct_pulse_src i_pct_pulse_src (.aclk(aclk), .pulse_pin(pin));

	// clock
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	task automatic fail(input string m);
		miscompares++;
		$display("[FAIL] %0t %s", $time, m);
	endtask

	task automatic cmp(input logic g, input logic x, input string m);
		n_checks++;
		if (g !== x) fail(m);
	endtask

	// bus write; the expected response is queued for the monitor
	task automatic wr(input pct_addr_t a, input logic [31:0] d, input pct_resp_t r = RESP_OKAY,
		input pct_strb_t s = 4'hf);
		logic aw_ok, w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		bq.push_back(r);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (awvalid && awready) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid && wready) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		@(posedge aclk);
	endtask

	// bus read; the accepted value range is queued for the monitor
	task automatic rd(input pct_addr_t a, input logic [31:0] lo, input logic [31:0] hi,
		input pct_resp_t r = RESP_OKAY);
		rq.push_back('{lo, hi, r});
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		@(posedge aclk);
	endtask

	// monitor: each response is matched against the oldest note
	always @(posedge aclk) begin
		if (bvalid && bready) begin
			n_checks++;
			if (bq.size() == 0) fail("unexpected write response");
			else if (bresp !== bq.pop_front()) fail("write response mismatch");
		end
		if (rvalid && rready) begin
			n_checks++;
			if (rq.size() == 0) fail("unexpected read data");
			else begin
				e = rq.pop_front();
				last_rd = rdata;
				if ((rdata >= e.lo && rdata <= e.hi) !== 1'b1 || rresp !== e.resp) begin
					fail($sformatf("read data %h outside %h..%h", rdata, e.lo, e.hi));
				end
			end
		end
	end

	task automatic give_verdict();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// watchdog against a hung handshake
	initial begin
		repeat (60000) @(posedge aclk);
		fail("watchdog expired");
		give_verdict();
	end

	initial begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready, ext_clk} = '0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = '0;
		void'($urandom(32'h0b30));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		// reset values and unmapped places
		foreach (regs[i]) rd(regs[i], 0, 0);
		wr({16'hff85, 2'b00}, 32'h0000_00ff, RESP_SLVERR);
		rd({16'hff85, 2'b00}, 0, 0, RESP_SLVERR);
		$display("test reset_map done");
		// counter and capture register hold software values while halted
		v1 = 16'($urandom);
		v2 = 16'($urandom);
		wr(ADDR_COUNT, {16'h0000, v1});
		wr(ADDR_GRA, {16'h0000, v2});
		repeat (40) @(posedge aclk);
		rd(ADDR_COUNT, v1, v1);
		rd(ADDR_GRA, v2, v2);
		wr(ADDR_COUNT, 32'h0000_abcd, RESP_OKAY, 4'h1);
		rd(ADDR_COUNT, {16'h0000, v1[15:8], 8'hcd}, {16'h0000, v1[15:8], 8'hcd});
		// park the compare value out of reach of the later counting tests
		wr(ADDR_GRA, 32'h0000_8000);
		$display("test halted_rw done");
		// internal prescaler codes, 240 cycles of run time plus bus overhead
		for (int k = 0; k < 4; k++) begin
			wr(ADDR_COUNT, 0);
			wr(ADDR_CTRL, k << 4);
			wr(ADDR_MODE, 32'h0000_0080);
			repeat (240) @(posedge aclk);
			wr(ADDR_MODE, 0);
			rd(ADDR_COUNT, 240 >> k, (252 >> k) + 1);
		end
		$display("test prescaler done");
		// external count clock, twenty rising edges
		wr(ADDR_CTRL, 32'h0000_0040);
		wr(ADDR_COUNT, 0);
		wr(ADDR_MODE, 32'h0000_0080);
		repeat (20) begin
			ext_clk <= 1'b1;
			repeat (2) @(posedge aclk);
			ext_clk <= 1'b0;
			repeat (2) @(posedge aclk);
		end
		repeat (6) @(posedge aclk);
		wr(ADDR_MODE, 0);
		rd(ADDR_COUNT, 20, 20);
		$display("test external_clock done");
		// overflow with the interrupt enabled, then blocked
		wr(ADDR_CTRL, 0);
		for (int en = 1; en >= 0; en--) begin
			wr(ADDR_IEN, en << 7);
			wr(ADDR_COUNT, 32'h0000_fff0);
			wr(ADDR_MODE, 32'h0000_0080);
			repeat (30) @(posedge aclk);
			cmp(irq, en[0], "overflow interrupt level");
			wr(ADDR_MODE, 0);
			rd(ADDR_STATUS, 32'h0000_0080, 32'h0000_0080);
			cmp(irq, 1'b0, "interrupt after status read");
			rd(ADDR_STATUS, 0, 0);
		end
		$display("test overflow done");
		// capture on each edge code with a halted counter
		wr(ADDR_IEN, 32'h0000_0001);
		for (int c = 0; c < 4; c++) begin
			v1 = 16'($urandom);
			v2 = 16'($urandom);
			wr(ADDR_IOC, 4 | c);
			wr(ADDR_COUNT, {16'h0000, v1});
			i_pct_pulse_src.drive(1'b1, 1 + $urandom % 5);
			repeat (8) @(posedge aclk);
			cmp(irq, c != 1, "interrupt after rising pin");
			rd(ADDR_STATUS, c != 1, c != 1);
			wr(ADDR_COUNT, {16'h0000, v2});
			i_pct_pulse_src.drive(1'b0, 1 + $urandom % 5);
			repeat (8) @(posedge aclk);
			rd(ADDR_STATUS, c != 0, c != 0);
			ex = (c == 0) ? v1 : v2;
			rd(ADDR_GRA, ex, ex);
		end
		$display("test capture_edges done");
		// compare mode: a pin pulse leaves the register alone
		wr(ADDR_IOC, 0);
		wr(ADDR_GRA, {16'h0000, v1});
		wr(ADDR_COUNT, {16'h0000, ~v1});
		i_pct_pulse_src.drive(1'b1, 2);
		i_pct_pulse_src.drive(1'b0, 6);
		repeat (8) @(posedge aclk);
		rd(ADDR_GRA, v1, v1);
		rd(ADDR_STATUS, 0, 0);
		cmp(irq, 1'b0, "no interrupt in compare mode");
		// compare mode with the counter running: a match sets the flag and the interrupt
		wr(ADDR_GRA, 32'h0000_0010);
		wr(ADDR_COUNT, 0);
		wr(ADDR_MODE, 32'h0000_0080);
		repeat (30) @(posedge aclk);
		cmp(irq, 1'b1, "compare match interrupt");
		wr(ADDR_MODE, 0);
		rd(ADDR_STATUS, 1, 1);
		rd(ADDR_GRA, 32'h0000_0010, 32'h0000_0010);
		$display("test compare_mode done");
		// pulse period at divide by eight from two rising captures, then across one overflow
		wr(ADDR_IOC, 4);
		wr(ADDR_CTRL, 32'h0000_0030);
		wr(ADDR_IEN, 32'h0000_0081);
		for (int ov = 0; ov < 2; ov++) begin
			n = (ov ? 1200 : 800) + $urandom % 400;
			wr(ADDR_COUNT, ov ? 32'h0000_ff80 : 0);
			wr(ADDR_MODE, 32'h0000_0080);
			fork
				begin
					i_pct_pulse_src.drive(1'b1, 2);
					i_pct_pulse_src.drive(1'b0, 4);
					i_pct_pulse_src.drive(1'b1, n - 4);
					i_pct_pulse_src.drive(1'b0, 4);
				end
				begin
					// the handler saves the first capture and clears its flag
					repeat (12) @(posedge aclk);
					rd(ADDR_GRA, 0, 32'h0000_ffff);
					g1 = last_rd[15:0];
					rd(ADDR_STATUS, 1, 1);
				end
			join
			repeat (8) @(posedge aclk);
			rd(ADDR_GRA, 0, 32'h0000_ffff);
			g2 = last_rd[15:0];
			rd(ADDR_STATUS, ov ? 32'h0000_0081 : 1, ov ? 32'h0000_0081 : 1);
			wr(ADDR_MODE, 0);
			p = g2 - g1 + (ov << 16);
			cmp(p >= n / 8 && p <= n / 8 + 1, 1'b1, "period off the pulse spacing");
			cmp(p < 32'h0002_0000 - g1, 1'b1, "period beyond one overflow");
		end
		$display("test pulse_period done");
		give_verdict();
	end
endmodule
